//--- rtl/pmb_pkg.sv
// Types of the power mode and brown-out controller
// Assumes one clock domain; all state lives in one packed struct
package pmb_pkg;
   typedef enum logic [4:0] {
      pmb_run     = 5'h01,
      pmb_idle    = 5'h02,
      pmb_pdown   = 5'h04,
      pmb_wake    = 5'h08,
      pmb_idlerst = 5'h10
   } pmb_mode_t;

   typedef struct packed {
      pmb_mode_t   fsm;
      logic [7:0]  pmc;
      logic [7:0]  flg;
      logic [7:0]  ckd;
      logic [7:0]  isp;
      logic [7:0]  aux;
      logic [7:0]  eie;
      logic [7:0]  runcfg;
      logic [15:0] wcnt;
      logic [1:0]  mcnt;
      logic [3:0]  srcnt;
      logic [6:0]  divcnt;
      logic        tick;
      logic        bo_s1;
      logic        bo_s2;
      logic        bo_d;
      logic        rp_s1;
      logic        rp_s2;
      logic        rp_d;
      logic [3:0]  ei_s1;
      logic [3:0]  ei_s2;
      logic        bor_hold;
      logic        kbd_wake;
      logic        kbd_irq;
      logic [7:0]  prdata;
   } pmb_state_t;
endpackage

//--- rtl/pmb_power_ctrl.sv
// Power mode, wakeup timing, brown-out and reset-cause logic, APB slave
// Assumes an interrupt controller reporting pending/enabled interrupts
// and async pins for brown-out comparator, reset pin and ext irq lines
//
// Overview of operation
// [RQ1] Idle request stops CPU clock, state kept
// [RQ2] Port pins hold levels during idle
// [RQ3] Peripherals run in idle; PCA, WDT configurable
// [RQ4] Enabled interrupt or reset ends idle
// [RQ5] Power-down request stops oscillator and macros
// [RQ6] Only listed wake events end power-down
// [RQ7] Firmware waits 4 us before re-entering power-down
// [RQ8] External line wakes only enabled, level-sensitive
// [RQ9] Interrupt wake runs counter before CPU clock
// [RQ10] Source holds interrupt level until execution starts
// [RQ11] Reset pin rise wakes; run after pin low
// [RQ12] Idle reset exit: two cycles, RAM blocked
// [RQ13] Keypad match wakes, then keypad interrupt
// [RQ14] Brown-out sets flag, optional interrupt request
// [RQ15] Flash writes rejected while supply is low
// [RQ16] Brown-out reset holds, flag set on recovery
// [RQ17] Power-down bit: set starts, exit clears
// [RQ18] Idle bit: set starts, exit clears
// [RQ19] Reset cause flags set by hardware, software clears
// [RQ20] Brown-out flag sticky; bits 3..1 read zero
// [RQ21] Divider selects clock over two to field
// [RQ22] Firmware writes 0x20 to trigger soft reset
// [RQ23] Soft reset trigger clears itself when done
// [RQ24] Power-on flag untouched by warm resets
// [RQ25] Brown-out reset enable selects reset action
// [RQ26] Wakeup counter length is a parameter
//
// The implementer's own choice: the APB register port.
`timescale 1ns/1ps
`include "pmb_regs.svh"

module pmb_power_ctrl #(
   parameter logic [15:0] WAKE_CYCLES = 16'(`PMB_WAKE_CYCLES) // see [RQ26]
) (
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic [11:0] paddr,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        brownout_low,
   input  wire logic        reset_pin,
   input  wire logic [3:0]  ext_irq_line,
   input  wire logic [3:0]  ext_irq_en,
   input  wire logic [3:0]  ext_irq_level,
   input  wire logic [3:0]  ext_irq_high_sel,
   input  wire logic        keypad_match,
   input  wire logic        irq_pending,
   input  wire logic        wdt_wake,
   input  wire logic        wdt_reset,
   input  wire logic        illegal_addr_reset,
   output logic             cpu_clk_en,
   output logic             port_hold,
   output logic             periph_clk_en,
   output logic             pca_clk_en,
   output logic             wdt_clk_en,
   output logic             osc_enable,
   output logic             macro_power_en,
   output logic             ram_access_block,
   output logic             flash_write_block,
   output logic             brownout_irq,
   output logic             keypad_interrupt,
   output logic             warm_reset,
   output logic             sysclk_tick
);

   localparam logic [1:0] MCYC_LAST = 2'(`PMB_IDLE_RST_MCYC - 1);
   localparam logic [3:0] SOFT_LAST = 4'(`PMB_SOFT_RST_CYC - 1);

   pmb_pkg::pmb_state_t s;
   pmb_pkg::pmb_state_t next_s;

   logic [9:0] idx;
   logic       hit;
   logic [7:0] rdv;
   logic       wr;
   logic [6:0] div_top;
   logic [3:0] ei_act;
   logic       ext_wake;
   logic       kbd_src;
   logic       pd_wake;
   logic       rp_rise;
   logic       idle_rst;

   // Register index from the word address
   assign idx = paddr[11:2];
   assign wr  = psel & penable & pwrite;

   // Read mux and decode; unmapped words answer with an error
   always_comb begin
      hit = 1'b1;
      rdv = 8'h00;
      if (idx == `PMB_IDX_PMC) begin
         rdv = s.pmc;
      end else if (idx == `PMB_IDX_FLG) begin
         rdv = s.flg & `PMB_FLG_MASK; // see [RQ20]
      end else if (idx == `PMB_IDX_CKD) begin
         rdv = s.ckd & `PMB_CKD_MASK;
      end else if (idx == `PMB_IDX_ISP) begin
         rdv = s.isp & `PMB_ISP_MASK;
      end else if (idx == `PMB_IDX_AUX) begin
         rdv = s.aux;
      end else if (idx == `PMB_IDX_EIE) begin
         rdv = s.eie;
      end else if (idx == `PMB_IDX_RUN) begin
         rdv = s.runcfg & `PMB_RUN_MASK;
      end else begin
         hit = 1'b0;
      end
   end

   // Zero wait state slave; error only in the access phase
   assign pready  = 1'b1;
   assign pslverr = psel & penable & ~hit;
   assign prdata  = {24'h000000, s.prdata};

   // Wake qualifiers from synchronised pins
   assign ei_act   = ~(s.ei_s2 ^ ext_irq_high_sel);
   assign ext_wake = |(ei_act & ext_irq_en & ext_irq_level); // see [RQ8] [RQ10]
   assign kbd_src  = keypad_match & s.eie[`PMB_EIE_EKB]; // see [RQ13]
   assign rp_rise  = s.rp_s2 & ~s.rp_d; // see [RQ11]
   assign pd_wake  = rp_rise | ext_wake | kbd_src
                   | (wdt_wake & s.runcfg[`PMB_RUN_WDT_PD]); // see [RQ6]
   assign idle_rst = s.rp_s2 | wdt_reset | (s.bo_s2 & s.aux[`PMB_AUX_BROWNOUT_RESET_ENABLE]);
   assign div_top  = 7'((8'h01 << s.ckd[2:0]) - 8'h01); // see [RQ21]

   // Next state: synchronisers, divider, registers, mode machine
   always_comb begin
      next_s = s;
      next_s.bo_s1 = brownout_low;
      next_s.bo_s2 = s.bo_s1;
      next_s.bo_d  = s.bo_s2;
      next_s.rp_s1 = reset_pin;
      next_s.rp_s2 = s.rp_s1;
      next_s.rp_d  = s.rp_s2;
      next_s.ei_s1 = ext_irq_line;
      next_s.ei_s2 = s.ei_s1;
      next_s.tick    = 1'b0;
      next_s.kbd_irq = 1'b0;

      // Slow clock enable; stops with the oscillator
      if (s.fsm == pmb_pkg::pmb_pdown) begin
         next_s.divcnt = 7'h00;
      end else if (s.divcnt >= div_top) begin
         next_s.divcnt = 7'h00;
         next_s.tick   = 1'b1; // see [RQ21]
      end else begin
         next_s.divcnt = s.divcnt + 7'h01;
      end

      // Read data captured in the setup phase
      if (psel & ~penable) begin
         next_s.prdata = rdv;
      end

      // Software writes first, so hardware sets below win
      if (wr) begin
         if (idx == `PMB_IDX_PMC) begin
            next_s.pmc = pwdata[7:0]; // see [RQ17] [RQ18]
         end else if (idx == `PMB_IDX_FLG) begin
            next_s.flg = pwdata[7:0] & `PMB_FLG_MASK; // see [RQ19]
         end else if (idx == `PMB_IDX_CKD) begin
            next_s.ckd = pwdata[7:0] & `PMB_CKD_MASK;
         end else if (idx == `PMB_IDX_ISP) begin
            next_s.isp = pwdata[7:0] & `PMB_ISP_MASK; // see [RQ22]
         end else if (idx == `PMB_IDX_AUX) begin
            next_s.aux = pwdata[7:0]; // see [RQ25]
         end else if (idx == `PMB_IDX_EIE) begin
            next_s.eie = pwdata[7:0];
         end else if (idx == `PMB_IDX_RUN) begin
            next_s.runcfg = pwdata[7:0] & `PMB_RUN_MASK;
         end
      end

      // Soft reset pulse, then trigger self-clears and cause is logged
      if (s.isp[`PMB_ISP_SOFT_RESET_TRIGGER]) begin
         if (s.srcnt == SOFT_LAST) begin
            next_s.srcnt = 4'h0;
            next_s.isp[`PMB_ISP_SOFT_RESET_TRIGGER] = 1'b0; // see [RQ23]
            next_s.flg[`PMB_FLG_SOFT_RESET_FLAG]  = 1'b1; // see [RQ19]
         end else begin
            next_s.srcnt = s.srcnt + 4'h1;
         end
      end

      // Brown-out: sticky flag, optional held reset, flag on recovery
      if (s.bo_s2 & ~s.bo_d) begin
         next_s.flg[`PMB_FLG_BOD] = 1'b1; // see [RQ14] [RQ20]
      end
      next_s.bor_hold = s.bo_s2 & s.aux[`PMB_AUX_BROWNOUT_RESET_ENABLE]; // see [RQ16] [RQ25]
      if (s.bor_hold & ~s.bo_s2) begin
         next_s.flg[`PMB_FLG_BROWNOUT_RESET_FLAG] = 1'b1; // see [RQ16]
      end

      // Pin reset logged when the pin returns low
      if (~s.rp_s2 & s.rp_d) begin
         next_s.flg[`PMB_FLG_PIN_RESET_FLAG] = 1'b1; // see [RQ19]
      end
      if (illegal_addr_reset) begin
         next_s.flg[`PMB_FLG_BAD_ADDRESS_RESET_FLAG] = 1'b1; // see [RQ19]
      end

      // Mode machine
      case (s.fsm)
         pmb_pkg::pmb_run: begin
            if (warm_reset) begin
               next_s.pmc[1:0] = 2'b00; // power-on flag untouched, see [RQ24]
            end else if (s.pmc[`PMB_PMC_PD]) begin
               next_s.fsm = pmb_pkg::pmb_pdown; // see [RQ5]
            end else if (s.pmc[`PMB_PMC_IDL]) begin
               next_s.fsm = pmb_pkg::pmb_idle; // see [RQ1]
            end
         end
         pmb_pkg::pmb_idle: begin
            if (idle_rst) begin
               next_s.fsm  = pmb_pkg::pmb_idlerst; // see [RQ4] [RQ12]
               next_s.mcnt = 2'b00;
            end else if (irq_pending) begin
               next_s.fsm = pmb_pkg::pmb_run; // see [RQ4]
               next_s.pmc[`PMB_PMC_IDL] = 1'b0; // see [RQ18]
            end
         end
         pmb_pkg::pmb_idlerst: begin
            // Counts machine cycles at the slow clock
            if (s.tick) begin
               if (s.mcnt == MCYC_LAST) begin
                  next_s.fsm = pmb_pkg::pmb_run; // see [RQ12]
                  next_s.pmc[`PMB_PMC_IDL] = 1'b0; // see [RQ18]
               end else begin
                  next_s.mcnt = s.mcnt + 2'b01;
               end
            end
         end
         pmb_pkg::pmb_pdown: begin
            if (pd_wake) begin
               next_s.fsm      = pmb_pkg::pmb_wake; // see [RQ6] [RQ9]
               next_s.wcnt     = 16'h0000;
               next_s.kbd_wake = kbd_src;
               next_s.pmc[`PMB_PMC_PD] = 1'b0; // see [RQ17]
            end
         end
         pmb_pkg::pmb_wake: begin
            // Oscillator settles before the CPU clock is released
            if (s.wcnt >= WAKE_CYCLES - 16'h0001) begin
               next_s.fsm     = pmb_pkg::pmb_run; // see [RQ9] [RQ26]
               next_s.kbd_irq = s.kbd_wake; // see [RQ13]
            end else begin
               next_s.wcnt = s.wcnt + 16'h0001;
            end
         end
         default: begin
            next_s.fsm = pmb_pkg::pmb_run;
         end
      endcase
   end

   // State register; power-on reset sets the power-on flag
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s        <= '0;
         s.fsm    <= pmb_pkg::pmb_run;
         s.pmc    <= `PMB_PMC_RST; // see [RQ24]
         s.aux    <= `PMB_AUX_RST;
      end else begin
         s <= next_s;
      end
   end

   // Clock gating and power outputs decoded from the mode
   assign cpu_clk_en     = (s.fsm == pmb_pkg::pmb_run)
                         | (s.fsm == pmb_pkg::pmb_idlerst); // see [RQ1] [RQ9]
   assign port_hold      = (s.fsm == pmb_pkg::pmb_idle)
                         | (s.fsm == pmb_pkg::pmb_pdown)
                         | (s.fsm == pmb_pkg::pmb_wake); // see [RQ2]
   assign periph_clk_en  = cpu_clk_en | (s.fsm == pmb_pkg::pmb_idle); // see [RQ3]
   assign pca_clk_en     = cpu_clk_en
                         | ((s.fsm == pmb_pkg::pmb_idle)
                            & s.runcfg[`PMB_RUN_PCA_IDLE]); // see [RQ3]
   assign wdt_clk_en     = cpu_clk_en
                         | ((s.fsm == pmb_pkg::pmb_idle)
                            & s.runcfg[`PMB_RUN_WDT_IDLE])
                         | ((s.fsm == pmb_pkg::pmb_pdown | s.fsm == pmb_pkg::pmb_wake)
                            & s.runcfg[`PMB_RUN_WDT_PD]); // see [RQ3]
   assign osc_enable     = (s.fsm != pmb_pkg::pmb_pdown); // see [RQ5]
   assign macro_power_en = osc_enable; // see [RQ5]
   // Port access is not blocked here, only RAM
   assign ram_access_block  = (s.fsm == pmb_pkg::pmb_idlerst); // see [RQ12]
   assign flash_write_block = s.bo_s2; // see [RQ15]
   assign brownout_irq      = s.flg[`PMB_FLG_BOD] & s.eie[`PMB_EIE_EBD]; // see [RQ14]
   assign keypad_interrupt  = s.kbd_irq;
   assign sysclk_tick       = s.tick;
   // Held while the pin is high; grace cycles in idle exit come first
   assign warm_reset = ((s.rp_s2 | s.bor_hold)
                        & (s.fsm != pmb_pkg::pmb_idlerst))
                     | s.isp[`PMB_ISP_SOFT_RESET_TRIGGER]; // see [RQ11] [RQ16]

   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   sequence s_wake_last;
      (s.fsm == pmb_pkg::pmb_wake) && (s.wcnt == WAKE_CYCLES - 16'h0001);
   endsequence
   sequence s_run_kbd;
      (s.fsm == pmb_pkg::pmb_run) && (keypad_interrupt == s.kbd_wake);
   endsequence

   chk_idle_clk_off: assert property (  // see [RQ1]
      (s.fsm == pmb_pkg::pmb_idle) |-> (!cpu_clk_en && port_hold && periph_clk_en))
      else $error("idle mode gating wrong");
   chk_idle_irq_exit: assert property (  // see [RQ4]
      (s.fsm == pmb_pkg::pmb_idle && irq_pending && !idle_rst)
      |=> (s.fsm == pmb_pkg::pmb_run && !s.pmc[`PMB_PMC_IDL]))
      else $error("idle not left on interrupt");
   chk_pd_osc_off: assert property (  // see [RQ5]
      (s.fsm == pmb_pkg::pmb_pdown) |-> (!osc_enable && !macro_power_en && !cpu_clk_en))
      else $error("oscillator runs in power-down");
   chk_pd_stays: assert property (  // see [RQ6]
      (s.fsm == pmb_pkg::pmb_pdown && !pd_wake) |=> (s.fsm == pmb_pkg::pmb_pdown))
      else $error("power-down left without wake event");
   chk_wake_release: assert property (  // see [RQ9]
      s_wake_last |=> s_run_kbd ##1 (!keypad_interrupt && cpu_clk_en))
      else $error("wake timeout end wrong");
   chk_wake_start: assert property (  // see [RQ17]
      (s.fsm == pmb_pkg::pmb_pdown && pd_wake)
      |=> (s.fsm == pmb_pkg::pmb_wake && !s.pmc[`PMB_PMC_PD] && !cpu_clk_en) [*2])
      else $error("wake counter not started");
   chk_idle_rst_ram: assert property (  // see [RQ12]
      (s.fsm == pmb_pkg::pmb_idle && idle_rst)
      |=> (ram_access_block && !warm_reset && cpu_clk_en))
      else $error("idle reset grace wrong");
   chk_flash_block: assert property (  // see [RQ15]
      $rose(s.bo_s2) |-> flash_write_block ##1 s.flg[`PMB_FLG_BOD])
      else $error("brown-out not handled");
   chk_soft_clear: assert property (  // see [RQ23]
      $rose(s.isp[`PMB_ISP_SOFT_RESET_TRIGGER]) |-> warm_reset[*4] ##1
      (!s.isp[`PMB_ISP_SOFT_RESET_TRIGGER] && s.flg[`PMB_FLG_SOFT_RESET_FLAG]))
      else $error("soft reset trigger not cleared");
   chk_pof_keep: assert property (  // see [RQ24]
      (warm_reset && !wr) |=> $stable(s.pmc[`PMB_PMC_POF]))
      else $error("power-on flag changed by warm reset");

   // Gating, keypad pulse, brown-out interrupt request and reset hold
   chk_pd_no_tick: assert property (  // see [RQ21]
      (s.fsm == pmb_pkg::pmb_pdown) |=> !sysclk_tick)
      else $error("slow clock ticks in power-down");
   chk_sleep_ports: assert property (  // see [RQ2] [RQ9]
      (s.fsm == pmb_pkg::pmb_pdown || s.fsm == pmb_pkg::pmb_wake) |-> (port_hold && !cpu_clk_en))
      else $error("ports or core clock free while asleep");
   chk_idle_pca_off: assert property (  // see [RQ3]
      (s.fsm == pmb_pkg::pmb_idle && !s.runcfg[`PMB_RUN_PCA_IDLE]) |-> !pca_clk_en)
      else $error("counter array clocked in idle");
   chk_kbd_pulse: assert property (  // see [RQ13]
      keypad_interrupt |=> !keypad_interrupt)
      else $error("keypad interrupt longer than one cycle");
   chk_bo_irq_req: assert property (  // see [RQ14]
      ($rose(s.bo_s2) && s.eie[`PMB_EIE_EBD] && !wr) |=> brownout_irq)
      else $error("brown-out interrupt not requested");
   chk_bor_hold: assert property (  // see [RQ16]
      (s.bo_s2 && s.aux[`PMB_AUX_BROWNOUT_RESET_ENABLE] && s.fsm != pmb_pkg::pmb_idle
       && s.fsm != pmb_pkg::pmb_idlerst) |=> warm_reset)
      else $error("brown-out reset not held");

endmodule

//--- rtl/pmb_regs.svh
// Register indices, field positions, reset values and timing counts
// Assumes byte address = 4 * index on a 32-bit APB, data in low byte
`ifndef PMB_REGS_SVH
`define PMB_REGS_SVH
`define PMB_IDX_PMC       10'h087
`define PMB_IDX_FLG       10'h097
`define PMB_IDX_CKD       10'h0c7
`define PMB_IDX_ISP       10'h0e7
`define PMB_IDX_AUX       10'h010
`define PMB_IDX_EIE       10'h011
`define PMB_IDX_RUN       10'h012
`define PMB_PMC_IDL       0
`define PMB_PMC_PD        1
`define PMB_PMC_POF       4
`define PMB_FLG_BOD       0
`define PMB_FLG_BAD_ADDRESS_RESET_FLAG      4
`define PMB_FLG_BROWNOUT_RESET_FLAG      5
`define PMB_FLG_PIN_RESET_FLAG      6
`define PMB_FLG_SOFT_RESET_FLAG      7
`define PMB_ISP_SOFT_RESET_TRIGGER     5
`define PMB_AUX_BROWNOUT_RESET_ENABLE      6
`define PMB_EIE_EKB       5
`define PMB_EIE_EBD       6
`define PMB_RUN_PCA_IDLE  0
`define PMB_RUN_WDT_IDLE  1
`define PMB_RUN_WDT_PD    2
`define PMB_PMC_RST       8'h10
`define PMB_AUX_RST       8'h24
`define PMB_FLG_MASK      8'hf1
`define PMB_CKD_MASK      8'h87
`define PMB_ISP_MASK      8'hf0
`define PMB_RUN_MASK      8'h07
`define PMB_WAKE_CYCLES   1024
`define PMB_IDLE_RST_MCYC 2
`define PMB_SOFT_RST_CYC  4
`endif

//--- verif/pmb_cpu_model.sv
// CPU-side stand-in that raises a pending interrupt while the core sleeps
// Assumes the controller's cpu_clk_en and port_hold outputs, one clock
`timescale 1ns/1ps
module pmb_cpu_model (
   input  wire logic       pclk,
   input  wire logic       presetn,
   input  wire logic       arm,
   input  wire logic [7:0] delay,
   input  wire logic       cpu_clk_en,
   input  wire logic       port_hold,
   output logic            irq_pending
);
   logic [7:0] cnt;

   // Count sleeping cycles, then hold the request until the core runs;
   // dropping it earlier would lose the wakeup, as on the real part
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt         <= 8'h00;
         irq_pending <= 1'b0;
      end else if (cpu_clk_en) begin
         cnt         <= 8'h00;
         irq_pending <= 1'b0; // Handler has taken it
      end else if (arm && port_hold && !irq_pending) begin
         cnt         <= cnt + 8'h01;
         irq_pending <= (cnt == delay);
      end
   end
endmodule

//--- verif/pmb_power_ctrl_tb.sv
// Self-checking bench for the power mode and brown-out controller
// Assumes the register map of pmb_regs.svh and a shortened wakeup count
`timescale 1ns/1ps
`include "pmb_regs.svh"
module pmb_power_ctrl_tb;
   localparam int W = 8;
   localparam logic [9:0] IDX_TAB [7] = '{`PMB_IDX_PMC, `PMB_IDX_FLG, `PMB_IDX_CKD,
      `PMB_IDX_ISP, `PMB_IDX_AUX, `PMB_IDX_EIE, `PMB_IDX_RUN};
   localparam logic [7:0] RST_TAB [7] = '{`PMB_PMC_RST, 8'h00, 8'h00, 8'h00,
      `PMB_AUX_RST, 8'h00, 8'h00};
   logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h00000000;
   logic        brownout_low = 1'b0, reset_pin = 1'b0, keypad_match = 1'b0;
   logic        wdt_wake = 1'b0, wdt_reset = 1'b0, bad_addr = 1'b0, arm = 1'b0;
   logic [3:0]  ext_line = 4'hf, ext_en = 4'h0, ext_level = 4'h0, ext_high = 4'h0;
   logic [31:0] prdata;
   logic        pready, pslverr, irq_pending, cpu_clk_en, port_hold, periph_clk_en;
   logic        pca_clk_en, wdt_clk_en, osc_enable, macro_power_en, ram_access_block;
   logic        flash_write_block, brownout_irq, keypad_interrupt, warm_reset, sysclk_tick;
   logic [4:0]  obs;
   logic [7:0]  rd, d;
   logic        err;
   int          miscompares = 0, cmp_count = 0, seed = 38, n, k;

   pmb_power_ctrl #(.WAKE_CYCLES(16'(W))) DUT (
      .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
      .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .brownout_low(brownout_low), .reset_pin(reset_pin), .ext_irq_line(ext_line),
      .ext_irq_en(ext_en), .ext_irq_level(ext_level), .ext_irq_high_sel(ext_high),
      .keypad_match(keypad_match), .irq_pending(irq_pending), .wdt_wake(wdt_wake),
      .wdt_reset(wdt_reset), .illegal_addr_reset(bad_addr), .cpu_clk_en(cpu_clk_en),
      .port_hold(port_hold), .periph_clk_en(periph_clk_en), .pca_clk_en(pca_clk_en),
      .wdt_clk_en(wdt_clk_en), .osc_enable(osc_enable), .macro_power_en(macro_power_en),
      .ram_access_block(ram_access_block), .flash_write_block(flash_write_block),
      .brownout_irq(brownout_irq), .keypad_interrupt(keypad_interrupt),
      .warm_reset(warm_reset), .sysclk_tick(sysclk_tick));

   pmb_cpu_model cpu (
      .pclk(pclk), .presetn(presetn), .arm(arm), .delay(8'h0a),
      .cpu_clk_en(cpu_clk_en), .port_hold(port_hold), .irq_pending(irq_pending));

   // Outputs the waits can poll by index
   assign obs = {sysclk_tick, warm_reset, ram_access_block, osc_enable, cpu_clk_en};

   // 125 MHz clock
   initial begin
      forever #4 pclk = ~pclk;
   end

   // Hang guard, far beyond the expected run of some two thousand cycles
   initial begin
      repeat (60000) @(posedge pclk);
      miscompares++;
      finish_test();
   end

   task automatic cmp_val(input logic [7:0] got, input logic [7:0] exp);
      cmp_count++;
      if (got !== exp) begin
         miscompares++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic cmp_bit(input logic got, input logic exp);
      cmp_val({7'h00, got}, {7'h00, exp});
   endtask

   // Expected spacing of slow-clock ticks
   function automatic logic [7:0] div_gap(input int sel);
      return 8'(1 << sel);
   endfunction

   // One APB transfer; signals change only just after a rising edge
   task automatic apb(input logic w, input logic [9:0] idx, input logic [7:0] wd);
      @(posedge pclk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= {idx, 2'b00};
      pwdata  <= {24'h000000, wd};
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata[7:0];
      err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic rdchk(input logic [9:0] idx, input logic [7:0] exp);
      apb(1'b0, idx, 8'h00);
      cmp_val(rd, exp);
   endtask

   // Bounded wait for an output; n holds the cycles taken
   task automatic wait_obs(input int b);
      n = 0;
      do begin
         @(negedge pclk);
         n++;
      end while (obs[b] !== 1'b1 && n < 400);
      cmp_bit(obs[b], 1'b1);
   endtask

   task automatic end_test(input string name);
      $display("test %s done", name);
   endtask

   task automatic finish_test();
      $display("compares %0d mismatches %0d", cmp_count, miscompares);
      if (miscompares == 0 && cmp_count > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask

   // Main sequence
   initial begin
      repeat (12) @(posedge pclk);
      presetn <= 1'b1;
      for (k = 0; k < 7; k++) rdchk(IDX_TAB[k], RST_TAB[k]);
      apb(1'b1, `PMB_IDX_FLG, 8'hff);
      rdchk(`PMB_IDX_FLG, 8'hff & `PMB_FLG_MASK);
      apb(1'b1, `PMB_IDX_FLG, 8'h00);
      rdchk(`PMB_IDX_FLG, 8'h00);
      apb(1'b0, 10'h3ff, 8'h00);
      cmp_bit(err, 1'b1);
      cmp_val(rd, 8'h00);
      end_test("registers");
      // Every divider code, random upper bits; third gap is clear of the change
      for (k = 0; k < 8; k++) begin
         d = (8'($random(seed)) & 8'hf8) | 8'(k);
         apb(1'b1, `PMB_IDX_CKD, d);
         rdchk(`PMB_IDX_CKD, d & `PMB_CKD_MASK);
         wait_obs(4);
         wait_obs(4);
         wait_obs(4);
         cmp_val(8'(n), div_gap(k));
      end
      apb(1'b1, `PMB_IDX_CKD, 8'h00);
      end_test("divider");
      // Idle with the counter array kept running, ended by the model
      apb(1'b1, `PMB_IDX_RUN, 8'h01);
      arm <= 1'b1;
      apb(1'b1, `PMB_IDX_PMC, 8'h11);
      repeat (2) @(negedge pclk);
      cmp_bit(cpu_clk_en, 1'b0);
      cmp_bit(port_hold, 1'b1);
      cmp_bit(periph_clk_en & pca_clk_en & !wdt_clk_en, 1'b1);
      wait_obs(0);
      @(posedge pclk);
      arm <= 1'b0;
      rdchk(`PMB_IDX_PMC, 8'h10);
      // Reset pin in idle: RAM blocked first, warm reset after
      apb(1'b1, `PMB_IDX_PMC, 8'h11);
      reset_pin <= 1'b1;
      wait_obs(2);
      cmp_bit(warm_reset, 1'b0);
      wait_obs(3);
      cmp_bit(ram_access_block, 1'b0);
      @(posedge pclk);
      reset_pin <= 1'b0;
      repeat (4) @(negedge pclk);
      rdchk(`PMB_IDX_FLG, 8'h40);
      rdchk(`PMB_IDX_PMC, 8'h10);
      end_test("idle");
      // Power-down ignores a pending interrupt and an edge-mode line
      arm <= 1'b1;
      ext_en <= 4'h1;
      ext_line <= 4'he;
      apb(1'b1, `PMB_IDX_PMC, 8'h12);
      repeat (30) @(negedge pclk);
      cmp_bit(macro_power_en, 1'b0);
      cmp_bit(osc_enable, 1'b0);
      @(posedge pclk);
      ext_level <= 4'h1;
      wait_obs(0);
      cmp_bit(n >= W + 1 && n <= W + 4, 1'b1);
      @(posedge pclk);
      ext_line <= 4'hf;
      ext_level <= 4'h0;
      arm <= 1'b0;
      rdchk(`PMB_IDX_PMC, 8'h10);
      repeat (500) @(posedge pclk);
      // Keypad match wakes, then the keypad interrupt follows the count
      apb(1'b1, `PMB_IDX_EIE, 8'h20);
      apb(1'b1, `PMB_IDX_PMC, 8'h12);
      repeat (3) @(posedge pclk);
      keypad_match <= 1'b1;
      wait_obs(1);
      @(posedge pclk);
      keypad_match <= 1'b0;
      wait_obs(0);
      cmp_bit(keypad_interrupt, 1'b1);
      repeat (500) @(posedge pclk);
      // Reset pin wakes power-down and holds reset until it falls
      apb(1'b1, `PMB_IDX_PMC, 8'h12);
      repeat (3) @(posedge pclk);
      reset_pin <= 1'b1;
      repeat (W + 8) @(negedge pclk);
      cmp_bit(osc_enable & warm_reset, 1'b1);
      @(posedge pclk);
      reset_pin <= 1'b0;
      repeat (4) @(negedge pclk);
      cmp_bit(warm_reset, 1'b0);
      end_test("power-down");
      // Soft reset: trigger clears itself, flag set, power-on flag kept
      apb(1'b1, `PMB_IDX_FLG, 8'h00);
      apb(1'b1, `PMB_IDX_ISP, 8'h20);
      wait_obs(3);
      repeat (8) @(posedge pclk);
      rdchk(`PMB_IDX_ISP, 8'h00);
      rdchk(`PMB_IDX_FLG, 8'h80);
      rdchk(`PMB_IDX_PMC, 8'h10);
      bad_addr <= 1'b1;
      @(posedge pclk);
      bad_addr <= 1'b0;
      rdchk(`PMB_IDX_FLG, 8'h90);
      end_test("soft reset");
      // Brown-out: flag, interrupt and flash lock; reset only once enabled
      apb(1'b1, `PMB_IDX_EIE, 8'h40);
      brownout_low <= 1'b1;
      repeat (6) @(negedge pclk);
      cmp_bit(brownout_irq & flash_write_block, 1'b1);
      cmp_bit(warm_reset, 1'b0);
      apb(1'b1, `PMB_IDX_AUX, 8'h64);
      wait_obs(3);
      cmp_bit(flash_write_block, 1'b1);
      @(posedge pclk);
      brownout_low <= 1'b0;
      repeat (6) @(negedge pclk);
      cmp_bit(warm_reset | flash_write_block, 1'b0);
      rdchk(`PMB_IDX_FLG, 8'hb1);
      end_test("brown-out");
      finish_test();
   end
endmodule
